// >>> rtl/fsp_pkg.sv
// Package with the constants, states and map of the flash self-program sequencer.
package fsp_pkg;

	// Flash page organisation.
	localparam int FSP_PAGE_W = 7;
	localparam int FSP_WORD_W = 6;
	localparam int FSP_WORDS = 64;
	localparam int FSP_PTR_W = FSP_PAGE_W + FSP_WORD_W;
	localparam int FSP_DATA_W = 16;
	localparam int FSP_AW = 8;

	// Register byte offsets on the bus.
	localparam logic [7:0] FSP_OFS_CTRL = 8'h00;
	localparam logic [7:0] FSP_OFS_PTR = 8'h04;
	localparam logic [7:0] FSP_OFS_DATA = 8'h08;
	localparam logic [7:0] FSP_OFS_ISSUE = 8'h0C;
	localparam logic [7:0] FSP_OFS_STAT = 8'h10;

	// Command codes in the low six control bits.
	localparam logic [5:0] FSP_CMD_LOAD = 6'h01;
	localparam logic [5:0] FSP_CMD_ERASE = 6'h03;
	localparam logic [5:0] FSP_CMD_WRITE = 6'h05;
	localparam logic [5:0] FSP_CMD_CLEAR = 6'h11;
	localparam int FSP_BIT_EN = 0;
	localparam int FSP_BIT_CLR = 4;
	localparam logic [5:0] FSP_CTRL_RST = 6'h00;

	// Store instruction window after a control write.
	localparam logic [2:0] FSP_WIN_CYC = 3'h4;

	// Operation times; counts derived from the 50 MHz clock.
	localparam longint FSP_CLK_HZ = 50000000;
	localparam longint FSP_ERASE_NS = 4000000;
	localparam longint FSP_WRITE_NS = 4000000;
	localparam int FSP_ERASE_CYC = int'((FSP_ERASE_NS * FSP_CLK_HZ) / 1000000000);
	localparam int FSP_WRITE_CYC = int'((FSP_WRITE_NS * FSP_CLK_HZ) / 1000000000);
	localparam int FSP_CNT_W = 20;
	localparam logic [15:0] FSP_BLANK_WORD = 16'hFFFF;

	typedef enum logic [1:0] {FSP_IDLE, FSP_ERASE, FSP_WRITE} fsp_state_t;

endpackage

// >>> rtl/fsp_page_buf.sv
// Temporary page buffer memory with a registered read port.
`timescale 1ns/1ns
module fsp_page_buf #(
	parameter int DW = 16,
	parameter int AW = 6
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_q
);

	logic [DW-1:0] mem [0:(1 << AW)-1];

	// Words land at any address, in any order.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data comes out of a register one cycle after the address.
	always_ff @(posedge clk) begin
		rdata_q <= mem[raddr];
	end

endmodule

// >>> rtl/fsp_sequencer.sv
// Flash self-program sequencer: APB registers, store instruction window, erase and write.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module fsp_sequencer #(
	parameter int unsigned ERASE_CYCLES = fsp_pkg::FSP_ERASE_CYC,
	parameter int unsigned WRITE_CYCLES = fsp_pkg::FSP_WRITE_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fsp_pkg::FSP_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic eeprom_busy,
	output logic cpu_stall,
	output logic flash_erase,
	output logic flash_prog,
	output logic [fsp_pkg::FSP_PAGE_W-1:0] flash_page,
	output logic [fsp_pkg::FSP_WORD_W-1:0] flash_word,
	output logic [fsp_pkg::FSP_DATA_W-1:0] flash_wdata,
	output logic flash_wstb
);
	import fsp_pkg::*;

	logic rst_meta_q;
	logic rst_sync_q;
	logic rst_n;
	logic eep_meta_q;
	logic eep_sync_q;
	logic eep_prev_q;
	logic eep_rise;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic addr_hit;
	logic acc;
	logic wr_done;
	logic wr_ctrl;
	logic wr_issue;
	logic code_ok;
	logic ctrl_take;
	logic spm_ok;
	logic load_go;
	logic erase_go;
	logic write_go;
	logic op_end;
	logic write_end;
	logic [5:0] cmd_q;
	logic [2:0] win_q;
	logic [FSP_PTR_W-1:0] ptr_q;
	logic [FSP_DATA_W-1:0] data_q;
	logic [FSP_WORDS-1:0] valid_q;
	fsp_state_t state_q;
	logic [FSP_CNT_W-1:0] cnt_q;
	logic [FSP_CNT_W-1:0] erase_last;
	logic [FSP_CNT_W-1:0] write_last;
	logic [FSP_CNT_W-1:0] word_cnt;
	logic [FSP_WORD_W-1:0] stream_idx;
	logic [FSP_DATA_W-1:0] buf_rdata;
	logic cpu_stall_q;
	logic flash_erase_q;
	logic flash_prog_q;
	logic [FSP_PAGE_W-1:0] flash_page_q;
	logic [FSP_WORD_W-1:0] flash_word_q;
	logic [FSP_DATA_W-1:0] flash_wdata_q;
	logic flash_wstb_q;

	// Reset is asserted at once and released through two flip-flops.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	// The EEPROM busy level comes from another block and is synchronised first.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			eep_meta_q <= 1'b0;
			eep_sync_q <= 1'b0;
			eep_prev_q <= 1'b0;
		end else begin
			eep_meta_q <= eeprom_busy;
			eep_sync_q <= eep_meta_q;
			eep_prev_q <= eep_sync_q;
		end
	end
	assign eep_rise = eep_sync_q & ~eep_prev_q;

	// Bus decode; a transfer completes at the edge that samples pready high.
	assign acc = psel & penable;
	assign wr_done = acc & pready_q & pwrite;
	assign wr_ctrl = wr_done & (paddr == FSP_OFS_CTRL);
	assign wr_issue = wr_done & (paddr == FSP_OFS_ISSUE);
	assign addr_hit = (paddr == FSP_OFS_CTRL) | (paddr == FSP_OFS_PTR) |
		(paddr == FSP_OFS_DATA) | (paddr == FSP_OFS_ISSUE) | (paddr == FSP_OFS_STAT);

	// Only the defined codes are taken, and never while the EEPROM writes.
	assign code_ok = (pwdata[5:0] == FSP_CMD_LOAD) | (pwdata[5:0] == FSP_CMD_ERASE) |
		(pwdata[5:0] == FSP_CMD_WRITE) | (pwdata[5:0] == FSP_CMD_CLEAR);
	assign ctrl_take = wr_ctrl & code_ok & ~eep_sync_q & (state_q == FSP_IDLE);

	// A store instruction acts only while the enable window is open.
	assign spm_ok = wr_issue & cmd_q[FSP_BIT_EN] & (win_q != 3'h0) &
		(state_q == FSP_IDLE) & ~eep_sync_q;
	assign load_go = spm_ok & (cmd_q == FSP_CMD_LOAD);
	assign erase_go = spm_ok & (cmd_q == FSP_CMD_ERASE);
	assign write_go = spm_ok & (cmd_q == FSP_CMD_WRITE);

	// Operation end points as counter values.
	assign erase_last = FSP_CNT_W'(ERASE_CYCLES - 1);
	assign write_last = FSP_CNT_W'(WRITE_CYCLES - 1);
	assign write_end = (state_q == FSP_WRITE) & (cnt_q == write_last);
	assign op_end = write_end | ((state_q == FSP_ERASE) & (cnt_q == erase_last));

	// Bus handshake: one wait state so read data leaves a register.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= acc & ~pready_q;
			if (acc & ~pready_q) begin
				pslverr_q <= ~addr_hit;
				prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	// Read view of the registers; unmapped addresses read zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			FSP_OFS_CTRL: rd_mux[5:0] = cmd_q;
			FSP_OFS_PTR: rd_mux[FSP_PTR_W-1:0] = ptr_q;
			FSP_OFS_DATA: rd_mux[FSP_DATA_W-1:0] = data_q;
			FSP_OFS_STAT: rd_mux[2:0] = {|valid_q, eep_sync_q, cpu_stall_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Address pointer and data register pair.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= '0;
			data_q <= '0;
		end else if (wr_done & (paddr == FSP_OFS_PTR)) begin
			ptr_q <= pwdata[FSP_PTR_W-1:0];
		end else if (wr_done & (paddr == FSP_OFS_DATA)) begin
			data_q <= pwdata[FSP_DATA_W-1:0];
		end
	end

	// Control code and its four-cycle window; the enable bit clears itself.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= FSP_CTRL_RST;
			win_q <= 3'h0;
		end else if (ctrl_take) begin
			cmd_q <= pwdata[5:0];
			win_q <= FSP_WIN_CYC;
		end else if (state_q != FSP_IDLE) begin
			if (op_end) begin
				cmd_q <= FSP_CTRL_RST;
			end
		end else if (erase_go | write_go) begin
			win_q <= 3'h0;
		end else if (spm_ok) begin
			cmd_q <= FSP_CTRL_RST;
			win_q <= 3'h0;
		end else if (win_q != 3'h0) begin
			win_q <= win_q - 3'h1;
			if (win_q == 3'h1) begin
				cmd_q <= FSP_CTRL_RST;
			end
		end
	end

	// Loaded marks: a clear word reads as blank flash.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= '0;
		end else if (write_end | (ctrl_take & pwdata[FSP_BIT_CLR])) begin
			valid_q <= '0;
		end else if (eep_rise & (|valid_q)) begin
			valid_q <= '0;
		end else if (load_go) begin
			valid_q[ptr_q[FSP_WORD_W-1:0]] <= 1'b1;
		end
	end

	// The streaming index trails the counter by one for the read register.
	assign word_cnt = cnt_q - FSP_CNT_W'(1);
	assign stream_idx = word_cnt[FSP_WORD_W-1:0];

	fsp_page_buf #(
		.DW(FSP_DATA_W),
		.AW(FSP_WORD_W)
	) u_buf (
		.clk(sys_clk),
		.we(load_go),
		.waddr(ptr_q[FSP_WORD_W-1:0]),
		.wdata(data_q),
		.raddr(cnt_q[FSP_WORD_W-1:0]),
		.rdata_q(buf_rdata)
	);

	// Sequence of a page operation; the page comes from the page field only.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= FSP_IDLE;
			cnt_q <= '0;
			flash_page_q <= '0;
		end else begin
			case (state_q)
				FSP_IDLE: begin
					cnt_q <= '0;
					if (erase_go) begin
						state_q <= FSP_ERASE;
						flash_page_q <= ptr_q[FSP_PTR_W-1:FSP_WORD_W];
					end else if (write_go) begin
						state_q <= FSP_WRITE;
						flash_page_q <= ptr_q[FSP_PTR_W-1:FSP_WORD_W];
					end
				end
				FSP_ERASE, FSP_WRITE: begin
					cnt_q <= cnt_q + FSP_CNT_W'(1);
					if (op_end) begin
						state_q <= FSP_IDLE;
					end
				end
				default: begin
					state_q <= FSP_IDLE;
				end
			endcase
		end
	end

	// Stall and flash strobes follow the state with no gap.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_stall_q <= 1'b0;
			flash_erase_q <= 1'b0;
			flash_prog_q <= 1'b0;
		end else if (erase_go) begin
			cpu_stall_q <= 1'b1;
			flash_erase_q <= 1'b1;
		end else if (write_go) begin
			cpu_stall_q <= 1'b1;
			flash_prog_q <= 1'b1;
		end else if (op_end) begin
			cpu_stall_q <= 1'b0;
			flash_erase_q <= 1'b0;
			flash_prog_q <= 1'b0;
		end
	end

	// Page write streams every buffer word out, blank where none was loaded.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_wstb_q <= 1'b0;
			flash_word_q <= '0;
			flash_wdata_q <= '0;
		end else begin
			flash_wstb_q <= (state_q == FSP_WRITE) & (cnt_q >= FSP_CNT_W'(1)) &
				(cnt_q <= FSP_CNT_W'(FSP_WORDS));
			flash_word_q <= stream_idx;
			flash_wdata_q <= valid_q[stream_idx] ? buf_rdata : FSP_BLANK_WORD;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign cpu_stall = cpu_stall_q;
	assign flash_erase = flash_erase_q;
	assign flash_prog = flash_prog_q;
	assign flash_page = flash_page_q;
	assign flash_word = flash_word_q;
	assign flash_wdata = flash_wdata_q;
	assign flash_wstb = flash_wstb_q;

	// Checks on the sequencer, all in the system clock domain.
	default clocking chk_cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_write_done;
		(state_q == FSP_WRITE) ##1 (state_q == FSP_IDLE);
	endsequence

	sequence seq_erase_run;
		(state_q == FSP_ERASE) && flash_erase_q && cpu_stall_q;
	endsequence

	sequence seq_stream_start;
		(flash_prog_q && !flash_wstb_q) ##2 (flash_wstb_q && (flash_word_q == '0));
	endsequence

	chk_erase_start: assert property (erase_go |=> seq_erase_run)
		else $error("erase did not start after a store instruction");
	chk_stall_erase: assert property ((state_q == FSP_ERASE) |-> cpu_stall_q)
		else $error("core not stalled during erase");
	chk_stall_write: assert property ((state_q == FSP_WRITE) |-> cpu_stall_q)
		else $error("core not stalled during page write");
	chk_erase_page: assert property (erase_go |=>
		flash_page == $past(ptr_q[FSP_PTR_W-1:FSP_WORD_W]))
		else $error("erase page not taken from the page field");
	chk_load_mark: assert property (load_go |=> valid_q[$past(ptr_q[FSP_WORD_W-1:0])])
		else $error("loaded word not marked in buffer");
	chk_clear_write: assert property (seq_write_done |-> valid_q == '0)
		else $error("buffer not cleared after page write");
	chk_window_close: assert property ((state_q == FSP_IDLE) && (win_q == 3'h0)
		|-> !cmd_q[FSP_BIT_EN])
		else $error("enable bit outlived its window");
	chk_en_busy: assert property ((state_q != FSP_IDLE) |-> cmd_q[FSP_BIT_EN])
		else $error("enable bit dropped during an operation");
	chk_bad_code: assert property (wr_ctrl && !code_ok && (win_q == 3'h0) &&
		(state_q == FSP_IDLE) |=> cmd_q == FSP_CTRL_RST)
		else $error("undefined control code took effect");
	chk_eeprom_block: assert property (eep_sync_q && (state_q == FSP_IDLE)
		|=> state_q == FSP_IDLE)
		else $error("flash operation started during EEPROM write");

	// Buffer clears, window closing, the stall and the start of the page stream.
	chk_stream_start: assert property (write_go |=> seq_stream_start)
		else $error("page write stream did not start with word zero");
	chk_write_strobe: assert property (flash_wstb_q |-> flash_prog_q)
		else $error("word strobe outside a page write");
	chk_clear_bit: assert property (ctrl_take && pwdata[FSP_BIT_CLR] |=> valid_q == '0)
		else $error("clear bit left loaded words in the buffer");
	chk_eeprom_discard: assert property (eep_rise && (|valid_q) |=> valid_q == '0)
		else $error("loaded words kept across an EEPROM write");
	chk_load_closes: assert property (load_go |=> cmd_q == FSP_CTRL_RST)
		else $error("enable bit kept after a buffer load");
	chk_stall_busy: assert property (cpu_stall_q |-> (state_q != FSP_IDLE))
		else $error("core stalled with no operation running");
	chk_late_issue: assert property (wr_issue && (win_q == 3'h0) && (state_q == FSP_IDLE)
		|=> (state_q == FSP_IDLE) && !cpu_stall_q)
		else $error("store instruction acted outside its window");

endmodule

// >>> dv/fsp_core_model.sv
// Core-side model that issues APB transfers toward the sequencer.
`timescale 1ns/1ns
module fsp_core_model (
	input wire logic sys_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [fsp_pkg::FSP_AW-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import fsp_pkg::*;

	logic tmo = 1'b0;

	// Bus is idle from time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// One transfer, entered just after a rising edge; keep leaves psel up for the next setup.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic keep, output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		tmo = tmo | (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		// Held psel lets the issue follow a control write well inside the window.
		if (!keep) begin
			psel <= 1'b0;
			penable <= 1'b0;
			// One idle edge so the next setup never reassigns psel in this time step.
			@(posedge sys_clk);
		end
	endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench for the flash self-program sequencer.
`timescale 1ns/1ns
module tb;
	import fsp_pkg::*;
	localparam int ECYC = 80;
	localparam int WCYC = 80;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic eeprom_busy = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, cpu_stall;
	logic flash_erase, flash_prog, flash_wstb, err;
	logic [FSP_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [FSP_PAGE_W-1:0] flash_page, pg, p;
	logic [FSP_WORD_W-1:0] flash_word;
	logic [FSP_DATA_W-1:0] flash_wdata;
	logic [FSP_DATA_W-1:0] exp_buf [FSP_WORDS];
	logic [FSP_DATA_W-1:0] got [FSP_WORDS];
	int ord [FSP_WORDS];
	int seed = 96428;
	int mismatches = 0;
	int tests_run = 0;
	int n_er, n_st, n_stb, n_pg, j, t;

	fsp_sequencer #(.ERASE_CYCLES(ECYC), .WRITE_CYCLES(WCYC)) i_fsp_sequencer (
		.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.eeprom_busy(eeprom_busy), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
		.flash_prog(flash_prog), .flash_page(flash_page), .flash_word(flash_word),
		.flash_wdata(flash_wdata), .flash_wstb(flash_wstb));

	fsp_core_model i_fsp_core_model (
		.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// Clock of 20 ns period.
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	// Counts erase and stall cycles and captures streamed words.
	always @(posedge sys_clk) begin
		if (flash_erase === 1'b1) begin
			n_er++;
			pg = flash_page;
		end
		if (flash_prog === 1'b1) begin
			n_pg++;
			pg = flash_page;
		end
		if (cpu_stall === 1'b1) n_st++;
		if (flash_wstb === 1'b1) begin
			got[flash_word] = flash_wdata;
			n_stb++;
		end
	end

	function automatic logic [31:0] ptr(input logic [6:0] pp, input logic [5:0] w);
		return {19'h0, pp, w};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic k);
		i_fsp_core_model.xfer(w, a, d, k, rd, err);
		if (i_fsp_core_model.tmo) begin
			mismatches++;
			end_of_test();
		end
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 1'b0);
		chk(nm, rd, exp);
	endtask

	// Each location is loaded once per buffer fill.
	task automatic load(input int w);
		exp_buf[w] = 16'($random(seed));
		bus(1'b1, FSP_OFS_PTR, ptr(p, 6'(w)), 1'b0);
		bus(1'b1, FSP_OFS_DATA, {16'h0, exp_buf[w]}, 1'b0);
		bus(1'b1, FSP_OFS_CTRL, 32'(FSP_CMD_LOAD), 1'b1);
		bus(1'b1, FSP_OFS_ISSUE, 32'h0, 1'b0);
	endtask

	task automatic op(input logic [5:0] c, input logic [31:0] pv);
		bus(1'b1, FSP_OFS_PTR, pv, 1'b0);
		bus(1'b1, FSP_OFS_CTRL, 32'(c), 1'b1);
		bus(1'b1, FSP_OFS_ISSUE, 32'h0, 1'b0);
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (cpu_stall !== 1'b0 && k < 400);
		if (cpu_stall !== 1'b0) begin
			mismatches++;
			end_of_test();
		end
	endtask

	// Main sequence.
	initial begin
		for (int i = 0; i < FSP_WORDS; i++) begin
			exp_buf[i] = FSP_BLANK_WORD;
			ord[i] = i;
		end
		for (int i = FSP_WORDS - 1; i > 0; i--) begin
			j = ($random(seed) & 32'h7FFF_FFFF) % (i + 1);
			t = ord[i];
			ord[i] = ord[j];
			ord[j] = t;
		end
		p = 7'($random(seed));
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd_chk("ctrl_rst", FSP_OFS_CTRL, 32'h0);
		rd_chk("stat_rst", FSP_OFS_STAT, 32'h0);
		bus(1'b0, 8'h14, 32'h0, 1'b0);
		chk("unmapped_err", {31'h0, err}, 32'h1);
		chk("unmapped_data", rd, 32'h0);
		// Old words are kept in the buffer across the erase and written back.
		for (int i = 0; i < 12; i++) load(ord[i]);
		rd_chk("stat_loaded", FSP_OFS_STAT, 32'h4);
		n_st = 0;
		n_er = 0;
		op(FSP_CMD_ERASE, ptr(p, 6'h2A));
		rd_chk("ctrl_erase", FSP_OFS_CTRL, 32'h3);
		wait_idle();
		chk("erase_cycles", n_st, ECYC);
		chk("erase_strobe", n_er, ECYC);
		chk("erase_page", pg, p);
		for (int i = 12; i < 16; i++) load(ord[i]);
		n_st = 0;
		n_stb = 0;
		n_pg = 0;
		pg = ~p;
		op(FSP_CMD_WRITE, ptr(p, 6'h0));
		wait_idle();
		chk("write_stall", n_st, WCYC);
		chk("write_prog", n_pg, WCYC);
		chk("write_page", pg, p);
		chk("write_words", n_stb, FSP_WORDS);
		for (int i = 0; i < FSP_WORDS; i++) chk("write_data", got[i], exp_buf[i]);
		rd_chk("stat_after_wr", FSP_OFS_STAT, 32'h0);
		rd_chk("ctrl_after_wr", FSP_OFS_CTRL, 32'h0);
		bus(1'b1, FSP_OFS_CTRL, 32'(FSP_CMD_LOAD), 1'b0);
		repeat (6) @(posedge sys_clk);
		rd_chk("ctrl_expired", FSP_OFS_CTRL, 32'h0);
		bus(1'b1, FSP_OFS_ISSUE, 32'h0, 1'b0);
		rd_chk("late_issue", FSP_OFS_STAT, 32'h0);
		for (int c = 0; c < 64; c++) begin
			if (c != 1 && c != 3 && c != 5 && c != 17) begin
				bus(1'b1, FSP_OFS_CTRL, 32'(c), 1'b0);
				rd_chk("ctrl_undef", FSP_OFS_CTRL, 32'h0);
			end
		end
		load(ord[20]);
		bus(1'b1, FSP_OFS_CTRL, 32'(FSP_CMD_CLEAR), 1'b0);
		rd_chk("stat_cleared", FSP_OFS_STAT, 32'h0);
		repeat (6) @(posedge sys_clk);
		load(ord[21]);
		eeprom_busy <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd_chk("stat_eeprom", FSP_OFS_STAT, 32'h2);
		op(FSP_CMD_ERASE, ptr(p, 6'h0));
		rd_chk("ctrl_blocked", FSP_OFS_CTRL, 32'h0);
		chk("stall_blocked", {31'h0, cpu_stall}, 32'h0);
		eeprom_busy <= 1'b0;
		repeat (6) @(posedge sys_clk);
		load(ord[22]);
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd_chk("stat_reset", FSP_OFS_STAT, 32'h0);
		end_of_test();
	end
endmodule
